// ===== core/adis_defines.svh
// Overview of operation
// - write is address, two instruction bytes, stop
// - read returns four status bytes in order
// - read of the fourth status byte stops offset detection; bit 2 valid
// - after current detection only bit 5 valid
// - offset at threshold sets channel bit 2
// - second byte bit 4 selects operation
// - second byte bit 2 enables current detection
// - status byte 1 bit 6 flags cycle done
`ifndef ADIS_DEFINES_SVH
`define ADIS_DEFINES_SVH
`define ADIS_DEV_ADDR 7'h6c
`define ADIS_RW_BIT 0
`define ADIS_IB1_DIAG_BIT 6
`define ADIS_IB1_OFFSET_BIT 5
`define ADIS_IB2_STBY_BIT 4
`define ADIS_IB2_CURR_BIT 2
`define ADIS_DB_OFFSET_BIT 2
`define ADIS_DB_CURR_BIT 5
`define ADIS_DB1_DONE_BIT 6
`define ADIS_DB2_OFS_ACT_BIT 7
`define ADIS_DB2_CUR_ACT_BIT 6
`define ADIS_RESET_BYTE 8'h00
`define ADIS_CLK_PERIOD_NS 4
`define ADIS_DIAG_TIME_US 1000
`define ADIS_DIAG_CYCLES ((`ADIS_DIAG_TIME_US * 1000) / `ADIS_CLK_PERIOD_NS)
`endif

// ===== core/adis_pkg.sv
`default_nettype none
package adis_pkg;
  typedef enum logic [2:0] {
    ADIS_IDLE, ADIS_ADDR, ADIS_WR, ADIS_RD, ADIS_ACK_TX, ADIS_ACK_RX, ADIS_IGNORE
  } adis_state_e;
  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
  } adis_instr_s;
  typedef struct packed {
    logic [3:0] open_load;
    logic [3:0] offset_flag;
    logic [3:0] curr_low;
    logic [3:0] short_vcc;
    logic [3:0] short_gnd;
    logic thermal;
  } adis_meas_s;
endpackage : adis_pkg
`default_nettype wire

// ===== core/adis_i2c_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "adis_defines.svh"
module adis_i2c_seq #(
  parameter int unsigned DIAG_CYCLES = `ADIS_DIAG_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire adis_pkg::adis_meas_s meas_i,
  output adis_pkg::adis_instr_s instr_o,
  output logic amp_on_o,
  output logic diag_busy_o,
  output logic diag_done_o
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] scl_s_r, sda_s_r;
  logic scl_d_r, sda_d_r;
  adis_pkg::adis_meas_s meas_s1_r, meas_s2_r;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      meas_s1_r <= '0;
      meas_s2_r <= '0;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
      meas_s1_r <= meas_i;
      meas_s2_r <= meas_s1_r;
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s_r[1] & ~scl_d_r;
  assign scl_fall = ~scl_s_r[1] & scl_d_r;
  assign start_c = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
  assign stop_c = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

  // ------------------------------------------------------------
  // bus engine
  // ------------------------------------------------------------
  adis_pkg::adis_state_e st_r, st_nxt, after_r, after_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic sda_r, sda_nxt, oe_r, oe_nxt;
  logic [7:0] ib1_r, ib1_nxt, ib2_r, ib2_nxt;
  logic wr_done_c, rd_done_c;
  logic [7:0] db_c [4];
  logic [3:0] ofs_lat_r, ofs_lat_nxt;
  logic ofs_act_r, ofs_act_nxt, cur_act_r, cur_act_nxt, done_r, done_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic rd_end_c;

  always_comb begin
    st_nxt = st_r;
    after_nxt = after_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    idx_nxt = idx_r;
    sda_nxt = sda_r;
    oe_nxt = oe_r;
    ib1_nxt = ib1_r;
    ib2_nxt = ib2_r;
    wr_done_c = 1'b0;
    rd_end_c = 1'b0;
    if (stop_c) begin
      st_nxt = adis_pkg::ADIS_IDLE;
      oe_nxt = 1'b0;
      if (idx_r == 3'h2 && after_r == adis_pkg::ADIS_WR) begin
        wr_done_c = 1'b1;
      end
    end else if (start_c) begin
      st_nxt = adis_pkg::ADIS_ADDR;
      bit_nxt = 4'h0;
      idx_nxt = 3'h0;
      oe_nxt = 1'b0;
    end else begin
      unique case (st_r)
        adis_pkg::ADIS_IDLE, adis_pkg::ADIS_IGNORE: begin
        end
        adis_pkg::ADIS_ADDR, adis_pkg::ADIS_WR: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_s_r[1]};
            bit_nxt = bit_r + 4'h1;
          end
          if (scl_fall && bit_r == 4'h8) begin
            bit_nxt = 4'h0;
            if (st_r == adis_pkg::ADIS_ADDR) begin
              if (sh_r[7:1] == `ADIS_DEV_ADDR) begin
                st_nxt = adis_pkg::ADIS_ACK_TX;
                oe_nxt = 1'b1;
                sda_nxt = 1'b0;
                after_nxt = sh_r[`ADIS_RW_BIT] ? adis_pkg::ADIS_RD : adis_pkg::ADIS_WR;
              end else begin
                st_nxt = adis_pkg::ADIS_IGNORE;
              end
            end else if (idx_r < 3'h2) begin
              if (idx_r == 3'h0) ib1_nxt = sh_r;
              else ib2_nxt = sh_r;
              idx_nxt = idx_r + 3'h1;
              st_nxt = adis_pkg::ADIS_ACK_TX;
              oe_nxt = 1'b1;
              sda_nxt = 1'b0;
            end else begin
              st_nxt = adis_pkg::ADIS_IGNORE;
            end
          end
        end
        adis_pkg::ADIS_ACK_TX: begin
          if (scl_fall) begin
            st_nxt = after_r;
            oe_nxt = 1'b0;
            if (after_r == adis_pkg::ADIS_RD) begin
              sh_nxt = db_c[idx_r[1:0]];
              oe_nxt = ~db_c[idx_r[1:0]][7];
              sda_nxt = 1'b0;
              bit_nxt = 4'h1;
            end
          end
        end
        adis_pkg::ADIS_RD: begin
          if (scl_fall) begin
            if (bit_r == 4'h8) begin
              st_nxt = adis_pkg::ADIS_ACK_RX;
              oe_nxt = 1'b0;
              idx_nxt = idx_r + 3'h1;
              if (idx_r == 3'h3) rd_end_c = 1'b1;
            end else begin
              oe_nxt = ~sh_r[3'h7 - bit_r[2:0]];
              bit_nxt = bit_r + 4'h1;
            end
          end
        end
        adis_pkg::ADIS_ACK_RX: begin
          if (scl_rise && (sda_s_r[1] || idx_r == 3'h4)) begin
            st_nxt = adis_pkg::ADIS_IGNORE;
          end else if (scl_fall) begin
            // host acked: launch the next status byte, sda driven low when its bit 7 is 0
            st_nxt = adis_pkg::ADIS_RD;
            sh_nxt = db_c[idx_r[1:0]];
            oe_nxt = ~db_c[idx_r[1:0]][7];
            bit_nxt = 4'h1;
          end
        end
        default: st_nxt = adis_pkg::ADIS_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // diagnostic sequencer
  // ------------------------------------------------------------
  always_comb begin
    ofs_act_nxt = ofs_act_r;
    cur_act_nxt = cur_act_r;
    done_nxt = done_r;
    cnt_nxt = cnt_r;
    ofs_lat_nxt = ofs_lat_r;
    if (cnt_r != 32'h0) begin
      cnt_nxt = cnt_r - 32'h1;
      if (cnt_r == 32'h1) done_nxt = 1'b1;
    end
    if (rd_end_c) ofs_act_nxt = 1'b0;
    if (wr_done_c) begin
      ofs_act_nxt = ib1_r[`ADIS_IB1_OFFSET_BIT];
      if (ib1_r[`ADIS_IB1_OFFSET_BIT]) ofs_lat_nxt = 4'h0;
      cur_act_nxt = ib2_r[`ADIS_IB2_CURR_BIT];
      if (ib1_r[`ADIS_IB1_DIAG_BIT]) begin
        done_nxt = 1'b0;
        cnt_nxt = DIAG_CYCLES;
      end
    end
    // latch offset flags, a flag wins over a clear
    if (ofs_act_r) ofs_lat_nxt = ofs_lat_nxt | meas_s2_r.offset_flag;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= adis_pkg::ADIS_IDLE;
      after_r <= adis_pkg::ADIS_IDLE;
      sh_r <= `ADIS_RESET_BYTE;
      bit_r <= 4'h0;
      idx_r <= 3'h0;
      sda_r <= 1'b0;
      oe_r <= 1'b0;
      ib1_r <= `ADIS_RESET_BYTE;
      ib2_r <= `ADIS_RESET_BYTE;
      ofs_act_r <= 1'b0;
      cur_act_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= 32'h0;
      ofs_lat_r <= 4'h0;
      instr_o <= '0;
    end else begin
      st_r <= st_nxt;
      after_r <= after_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      idx_r <= idx_nxt;
      sda_r <= sda_nxt;
      oe_r <= oe_nxt;
      ib1_r <= ib1_nxt;
      ib2_r <= ib2_nxt;
      ofs_act_r <= ofs_act_nxt;
      cur_act_r <= cur_act_nxt;
      done_r <= done_nxt;
      cnt_r <= cnt_nxt;
      ofs_lat_r <= ofs_lat_nxt;
      if (wr_done_c) instr_o <= {ib1_r, ib2_r};
    end
  end

  // ------------------------------------------------------------
  // status bytes
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      db_c[i] = {2'h0, meas_s2_r.curr_low[i], 1'b0, 1'b0,
                 ofs_act_r ? ofs_lat_r[i] : meas_s2_r.open_load[i],
                 meas_s2_r.short_vcc[i], meas_s2_r.short_gnd[i]};
    end
    db_c[0][7] = meas_s2_r.thermal;
    db_c[0][`ADIS_DB1_DONE_BIT] = done_r;
    db_c[1][`ADIS_DB2_OFS_ACT_BIT] = ofs_act_r;
    db_c[1][`ADIS_DB2_CUR_ACT_BIT] = cur_act_r;
    db_c[2][7] = ib1_r[4];
    db_c[2][6] = ib1_r[`ADIS_IB1_DIAG_BIT];
  end

  assign sda_o = sda_r;
  assign sda_oe_o = oe_r;
  assign amp_on_o = instr_o.second[`ADIS_IB2_STBY_BIT];
  assign diag_busy_o = cnt_r != 32'h0;
  assign diag_done_o = done_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  ack_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_r == adis_pkg::ADIS_ACK_TX |-> oe_r && !sda_r)
    else $error("ack not driven low");
  offset_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_end_c && !wr_done_c |=> !ofs_act_r)
    else $error("offset not stopped by read");
  done_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_r == 32'h1 && !wr_done_c |=> done_r)
    else $error("done flag missing");
  write_commit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_done_c |=> instr_o == {$past(ib1_r), $past(ib2_r)})
    else $error("write not committed");
  standby_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    amp_on_o == instr_o.second[4])
    else $error("standby bit mismatch");
  curr_en_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_done_c |=> cur_act_r == $past(ib2_r[2]))
    else $error("current enable wrong");
  offset_latch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ofs_act_r && meas_s2_r.offset_flag[0] && !wr_done_c |=> ofs_lat_r[0])
    else $error("offset not latched");
  read_four_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_r == adis_pkg::ADIS_RD |-> idx_r < 3'h4)
    else $error("read past four bytes");
  write_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) wr_done_c);
  read_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) rd_end_c);
  diag_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(done_r));
endmodule : adis_i2c_seq
`default_nettype wire

// ===== testbench/adis_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module adis_host_model #(
  parameter int Q = 20
) (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i,
  output logic [7:0] res_o,
  output logic res_tgl_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    res_o = 8'h00;
    res_tgl_o = 1'b0;
  end
  task automatic bit_x(input logic b, output logic r);
    sda_o = b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask : bit_x
  task automatic byte_w(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    res_o = {7'h00, ~r};
    res_tgl_o = ~res_tgl_o;
  endtask : byte_w
  task automatic byte_r(input logic last);
    logic r;
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
    res_o = d;
    res_tgl_o = ~res_tgl_o;
  endtask : byte_r
  task automatic edge_x(input logic a, input logic b);
    sda_o = a;
    #Q scl_o = 1'b1;
    #Q sda_o = b;
    #Q scl_o = b;
    #Q;
  endtask : edge_x
  task automatic xfer(input logic [7:0] a, input logic [7:0] b1, input logic [7:0] b2);
    edge_x(1'b1, 1'b0);
    byte_w(a);
    if (a[0]) begin
      for (int k = 0; k < 4; k++) byte_r(k == 3);
    end else begin
      byte_w(b1);
      byte_w(b2);
    end
    edge_x(1'b0, 1'b1);
  endtask : xfer
endmodule : adis_host_model
`default_nettype wire

// ===== testbench/test_amp_diag_i2c_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_amp_diag_i2c_sequencer;
  typedef struct packed {logic [7:0] e; logic [7:0] m;} adis_note_s;
  localparam logic [6:0] ADDR = 7'h6c;
  logic clk_i, rst_n_i, scl, sda_m, sda_o, sda_oe_o, amp_on_o, busy, done, tgl;
  logic [7:0] res;
  adis_pkg::adis_meas_s meas_i;
  adis_pkg::adis_instr_s instr_o;
  adis_note_s note_q[$];
  adis_note_s n;
  int fail_count = 0;
  int checks_done = 0;
  wire sda_w = sda_m & ~sda_oe_o;
  adis_i2c_seq #(.DIAG_CYCLES(40)) i_adis_i2c_seq (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .meas_i(meas_i),
    .instr_o(instr_o), .amp_on_o(amp_on_o), .diag_busy_o(busy), .diag_done_o(done));
  adis_host_model i_adis_host_model (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_w),
    .res_o(res), .res_tgl_o(tgl));
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic tally_and_finish;
    check("leftover notes", 16'h0000, 16'(note_q.size()));
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  always @(tgl) begin
    if (rst_n_i !== 1'b1) begin
      // the start-up value of the toggle is no byte
    end else if (note_q.size() == 0) begin
      check("stray byte", 16'h0000, 16'h0001);
    end else begin
      n = note_q.pop_front();
      check("bus byte", {8'h00, n.e & n.m}, {8'h00, res & n.m});
    end
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] b1, b2, input logic ak);
    repeat (3) note_q.push_back({7'h00, ak, 8'h01});
    @(negedge clk_i);
    i_adis_host_model.xfer({a, 1'b0}, b1, b2);
  endtask : wr
  task automatic rd(input logic [31:0] e, input logic [31:0] m);
    note_q.push_back({8'h01, 8'h01});
    for (int k = 3; k >= 0; k--) note_q.push_back({e[8*k+:8], m[8*k+:8]});
    @(negedge clk_i);
    i_adis_host_model.xfer({ADDR, 1'b1}, 8'h00, 8'h00);
  endtask : rd
  task automatic wait_done;
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk_i);
    check("diag done", 16'h0001, {15'h0000, done});
    if (done !== 1'b1) tally_and_finish();
  endtask : wait_done
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    rst_n_i = 1'b0;
    meas_i = '0;
    void'($urandom(32'h09d9));
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    meas_i = 21'($urandom);
    repeat (4) @(negedge clk_i);
    check("instr reset", 16'h0000, instr_o);
    wr(ADDR, 8'h40, 8'h10, 1'b1);
    repeat (20) @(negedge clk_i);
    check("instr", 16'h4010, instr_o);
    check("amp on", 16'h0001, {15'h0000, amp_on_o});
    check("diag busy", 16'h0001, {15'h0000, busy});
    wait_done();
    rd({meas_i.thermal, 7'h40, 24'h0}, 32'hc000_0000);
    wr(7'h6d, 8'h00, 8'h00, 1'b0);
    check("instr kept", 16'h4010, instr_o);
    wr(ADDR, 8'h26, 8'h10, 1'b1);
    repeat (50) @(negedge clk_i);
    n = {5'h00, meas_i.offset_flag[0], 2'h0, 5'h10, meas_i.offset_flag[1], 2'h0};
    rd({n, 5'h00, meas_i.offset_flag[2], 7'h00, meas_i.offset_flag[3], 2'h0},
      32'h0484_0404);
    rd(32'h0, 32'h0080_0000);
    wr(ADDR, 8'h5e, 8'h14, 1'b1);
    wait_done();
    n = {2'h1, meas_i.curr_low[0], 7'h00, meas_i.curr_low[1], 5'h00};
    rd({n, 2'h0, meas_i.curr_low[2], 7'h00, meas_i.curr_low[3], 5'h00},
      32'h6020_2020);
    wr(ADDR, 8'h00, 8'h10, 1'b1);
    repeat (20) @(negedge clk_i);
    check("on mute", 16'h0010, instr_o);
    wr(ADDR, 8'h00, 8'h00, 1'b1);
    repeat (20) @(negedge clk_i);
    check("amp off", 16'h0000, {15'h0000, amp_on_o});
    check("sda drive level", 16'h0000, {15'h0000, sda_o});
    tally_and_finish();
  end
endmodule : test_amp_diag_i2c_sequencer
`default_nettype wire
